// ### include/vtic_map.svh
`ifndef VTIC_MAP_SVH
`define VTIC_MAP_SVH

// special-function register addresses
`define VTIC_ADDR_TIMER01_CONTROL 8'h88
`define VTIC_ADDR_EXT_FLAGS       8'h91
`define VTIC_ADDR_UART0_CONFIG    8'h98
`define VTIC_ADDR_PERIPH_SUM_ONE  8'h9e
`define VTIC_ADDR_PERIPH_SUM_TWO  8'h9f
`define VTIC_ADDR_IRQ_ENABLE      8'ha8
`define VTIC_ADDR_IRQ_PRIORITY    8'hb8
`define VTIC_ADDR_UART1_CONFIG    8'hc0
`define VTIC_ADDR_EXT_ENABLE      8'he8
`define VTIC_ADDR_EXT_PRIORITY    8'hf8

// reset values
`define VTIC_RST_IRQ_ENABLE   8'h00
`define VTIC_RST_IRQ_PRIORITY 8'h00
`define VTIC_RST_EXT_ENABLE   8'h00
`define VTIC_RST_EXT_PRIORITY 8'h00
`define VTIC_RST_TIMER01      8'h00
`define VTIC_RST_UART_CONFIG  8'h00
`define VTIC_RST_EXT_FLAGS    6'h00

// timer01_control fields
`define VTIC_TC_EXT_A_EDGE 0
`define VTIC_TC_EXT_A_FLAG 1
`define VTIC_TC_EXT_B_EDGE 2
`define VTIC_TC_EXT_B_FLAG 3
`define VTIC_TC_T0_RUN     4
`define VTIC_TC_T0_FLAG    5
`define VTIC_TC_T1_RUN     6
`define VTIC_TC_T1_FLAG    7

// uart config fields
`define VTIC_UC_RX_DONE 0
`define VTIC_UC_TX_DONE 1

// interrupt_enable global bit
`define VTIC_EN_GLOBAL 7

// extended flag / enable / priority fields
`define VTIC_EF_DMA    0
`define VTIC_EF_PCA    1
`define VTIC_EF_PERIPH 2
`define VTIC_EF_MSDMA  3
`define VTIC_EF_WAKE   4
`define VTIC_EF_WDOG   5
`define VTIC_EF_WIDTH  6

// source indices, natural priority is index plus one
`define VTIC_NUM_SRC    13
`define VTIC_SRC_EXT_A  0
`define VTIC_SRC_T0     1
`define VTIC_SRC_EXT_B  2
`define VTIC_SRC_T1     3
`define VTIC_SRC_DMA    7
`define VTIC_SRC_PCA    8
`define VTIC_SRC_PERIPH 9

// vector address = base + step * index
`define VTIC_VEC_BASE 8'h03
`define VTIC_VEC_STEP 8'h08

`endif

// ### include/vtic_pkg.sv
package vtic_pkg;

	// set pulses and levels from the on-chip sources
	typedef struct packed {
		logic timer0_ovf;
		logic timer1_ovf;
		logic timer_two_flag;
		logic uart0_tx;
		logic uart0_rx;
		logic uart1_tx;
		logic uart1_rx;
		logic dma;
		logic counter_array;
		logic periph;
		logic softdma_mstimer;
		logic wakeup;
		logic watchdog;
	} vtic_src_t;

	// special-function register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} vtic_sfr_t;

	// priority group of the request being offered
	typedef enum logic [0:0] {
		VTIC_GRP_LOW  = 1'b0,
		VTIC_GRP_HIGH = 1'b1
	} vtic_grp_t;

endpackage

// ### rtl/vtic_sync.sv
`timescale 1ns/1ps
`default_nettype none

// multi-stage synchroniser for asynchronous pins
module vtic_sync #(
	parameter int WIDTH  = 2,
	parameter int STAGES = 2
) (
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage [STAGES];

	// fewer than two stages would leave metastability exposed
	if (STAGES < 2 || WIDTH < 1) begin : g_bad
		$error("vtic_sync: STAGES must be >= 2 and WIDTH >= 1");
	end

	// reset to idle-high, the pins are active low
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int s = 0; s < STAGES; s++) stage[s] <= '1;
		end else begin
			stage[0] <= async_in;
			for (int s = 1; s < STAGES; s++) stage[s] <= stage[s-1];
		end
	end

	assign sync_out = stage[STAGES-1];

endmodule // vtic_sync

`default_nettype wire

// ### rtl/vtic_core.sv
// Operation
// - two external pins; every source assignable to high or low group.
// - each pin selectable: level low or falling edge request.
// - each vector has its own enable bit; cleared bit blocks source.
// - global enable bit 7 of interrupt_enable gates every source.
// - pin A vectors to 0x03, priority 1, hardware-cleared flag.
// - timer 0 overflow vectors to 0x0B, priority 2, hardware cleared.
// - pin B vectors to 0x13, priority 3, hardware-cleared flag.
// - timer 1 overflow vectors to 0x1B, priority 4, hardware cleared.
// - uart 0 tx or rx vectors to 0x23, priority 5, software cleared.
// - timer 2 vectors to 0x2B, priority 6, software cleared.
// - uart 1 tx or rx vectors to 0x33, priority 7, software cleared.
// - dma vectors to 0x3B, priority 8, hardware cleared; advise high group.
// - counter array vectors to 0x43, priority 9, hardware cleared.
// - shared peripheral vectors to 0x4B, priority 10, hardware cleared.
// - soft dma / ms timer vectors to 0x53, priority 11, software cleared.
// - wake-up 0x5B priority 12, watchdog 0x63 priority 13, software cleared.
// - interrupt_enable resets to 0x00; bits 0..6 enable seven basic sources.
// - extended priority, flags and two peripheral summaries at fixed addresses.
// - interrupt_priority mirrors enable bit order; bit 7 reserved; 1 is high.
// - level pin flags follow pin; writing one never sets them, nor msdma/wake.
`timescale 1ns/1ps
`default_nettype none
`include "vtic_map.svh"

module vtic_core (
	input  wire logic               clk_sys,
	input  wire logic               sys_rst,
	input  wire logic               ext_irq_pin_a_n,
	input  wire logic               ext_irq_pin_b_n,
	input  wire vtic_pkg::vtic_src_t src_set,
	input  wire logic [7:0]         periph_sum_one_in,
	input  wire logic [7:0]         periph_sum_two_in,
	input  wire vtic_pkg::vtic_sfr_t sfr,
	output logic      [7:0]         sfr_rdata,
	input  wire logic               irq_ack,
	input  wire logic               irq_return,
	output logic                    irq_req,
	output logic      [7:0]         irq_vector,
	output logic      [1:0]         timer_run,
	output logic      [1:0]         in_service
);

	localparam int N = `VTIC_NUM_SRC;

	logic [7:0] interrupt_enable;
	logic [7:0] interrupt_priority;
	logic [7:0] extended_interrupt_enable;
	logic [7:0] extended_interrupt_priority;
	logic [7:0] timer01_control;
	logic [7:0] uart0_config;
	logic [7:0] uart1_config;
	logic [`VTIC_EF_WIDTH-1:0] extended_interrupt_flags;
	logic [7:0] next_timer01_control;
	logic [7:0] next_uart0_config;
	logic [7:0] next_uart1_config;
	logic [`VTIC_EF_WIDTH-1:0] next_ext_flags;
	logic [1:0] pin_sync;
	logic [1:0] pin_prev;
	logic [1:0] pin_fall;
	logic [N-1:0] flag_vec;
	logic [N-1:0] en_vec;
	logic [N-1:0] grp_vec;
	logic [N-1:0] pend;
	logic [N-1:0] hw_clear;
	logic [3:0] served_idx;
	vtic_pkg::vtic_grp_t served_grp;
	logic       hi_valid;
	logic       lo_valid;
	logic [3:0] hi_idx;
	logic [3:0] lo_idx;
	logic       grant;
	logic [3:0] grant_idx;
	vtic_pkg::vtic_grp_t grant_grp;
	logic       ins_hi;
	logic       ins_lo;

	// pins come from outside the clock domain
	vtic_sync #(
		.WIDTH  (2),
		.STAGES (2)
	) u_pin_sync (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.async_in ({ext_irq_pin_b_n, ext_irq_pin_a_n}),
		.sync_out (pin_sync)
	);

	// falling-edge detect on the synchronised pins
	always_ff @(posedge clk_sys) begin
		if (sys_rst) pin_prev <= 2'h3;
		else pin_prev <= pin_sync;
	end
	assign pin_fall = pin_prev & ~pin_sync;

	// hardware-cleared flags the core acknowledges are cleared on the acknowledge edge
	always_comb begin
		hw_clear = '0;
		if (irq_ack) hw_clear[served_idx] = 1'b1;
	end

	// basic enable and priority, read/write; priority bit 7 is always written as zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			interrupt_enable   <= `VTIC_RST_IRQ_ENABLE;
			interrupt_priority <= `VTIC_RST_IRQ_PRIORITY;
		end else if (sfr.wr) begin
			if (sfr.addr == `VTIC_ADDR_IRQ_ENABLE) interrupt_enable <= sfr.wdata;
			if (sfr.addr == `VTIC_ADDR_IRQ_PRIORITY)
				interrupt_priority <= {1'b0, sfr.wdata[6:0]};
		end
	end

	// extended enable and priority, plain read/write
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			extended_interrupt_enable   <= `VTIC_RST_EXT_ENABLE;
			extended_interrupt_priority <= `VTIC_RST_EXT_PRIORITY;
		end else if (sfr.wr) begin
			if (sfr.addr == `VTIC_ADDR_EXT_ENABLE) extended_interrupt_enable <= sfr.wdata;
			if (sfr.addr == `VTIC_ADDR_EXT_PRIORITY) extended_interrupt_priority <= sfr.wdata;
		end
	end

	// timer01_control: pin modes, pin flags, timer run and overflow flags
	always_comb begin
		next_timer01_control = timer01_control;
		if (sfr.wr && sfr.addr == `VTIC_ADDR_TIMER01_CONTROL) begin
			next_timer01_control[`VTIC_TC_EXT_A_EDGE] = sfr.wdata[`VTIC_TC_EXT_A_EDGE];
			next_timer01_control[`VTIC_TC_EXT_B_EDGE] = sfr.wdata[`VTIC_TC_EXT_B_EDGE];
			next_timer01_control[`VTIC_TC_T0_RUN]  = sfr.wdata[`VTIC_TC_T0_RUN];
			next_timer01_control[`VTIC_TC_T1_RUN]  = sfr.wdata[`VTIC_TC_T1_RUN];
			next_timer01_control[`VTIC_TC_T0_FLAG] = sfr.wdata[`VTIC_TC_T0_FLAG];
			next_timer01_control[`VTIC_TC_T1_FLAG] = sfr.wdata[`VTIC_TC_T1_FLAG];
			// software may only touch a pin flag in edge mode
			if (timer01_control[`VTIC_TC_EXT_A_EDGE])
				next_timer01_control[`VTIC_TC_EXT_A_FLAG] = sfr.wdata[`VTIC_TC_EXT_A_FLAG];
			if (timer01_control[`VTIC_TC_EXT_B_EDGE])
				next_timer01_control[`VTIC_TC_EXT_B_FLAG] = sfr.wdata[`VTIC_TC_EXT_B_FLAG];
		end
		// acknowledge clears; later sets override so a coincident event survives
		if (hw_clear[`VTIC_SRC_T0]) next_timer01_control[`VTIC_TC_T0_FLAG] = 1'b0;
		if (hw_clear[`VTIC_SRC_T1]) next_timer01_control[`VTIC_TC_T1_FLAG] = 1'b0;
		if (hw_clear[`VTIC_SRC_EXT_A] && timer01_control[`VTIC_TC_EXT_A_EDGE])
			next_timer01_control[`VTIC_TC_EXT_A_FLAG] = 1'b0;
		if (hw_clear[`VTIC_SRC_EXT_B] && timer01_control[`VTIC_TC_EXT_B_EDGE])
			next_timer01_control[`VTIC_TC_EXT_B_FLAG] = 1'b0;
		if (src_set.timer0_ovf) next_timer01_control[`VTIC_TC_T0_FLAG] = 1'b1;
		if (src_set.timer1_ovf) next_timer01_control[`VTIC_TC_T1_FLAG] = 1'b1;
		// level mode: the flag simply follows the pin
		if (!next_timer01_control[`VTIC_TC_EXT_A_EDGE])
			next_timer01_control[`VTIC_TC_EXT_A_FLAG] = ~pin_sync[0];
		else if (pin_fall[0])
			next_timer01_control[`VTIC_TC_EXT_A_FLAG] = 1'b1;
		if (!next_timer01_control[`VTIC_TC_EXT_B_EDGE])
			next_timer01_control[`VTIC_TC_EXT_B_FLAG] = ~pin_sync[1];
		else if (pin_fall[1])
			next_timer01_control[`VTIC_TC_EXT_B_FLAG] = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) timer01_control <= `VTIC_RST_TIMER01;
		else timer01_control <= next_timer01_control;
	end

	// uart configs: done flags set by the uart, cleared only by software
	always_comb begin
		next_uart0_config = uart0_config;
		next_uart1_config = uart1_config;
		if (sfr.wr && sfr.addr == `VTIC_ADDR_UART0_CONFIG) next_uart0_config = sfr.wdata;
		if (sfr.wr && sfr.addr == `VTIC_ADDR_UART1_CONFIG) next_uart1_config = sfr.wdata;
		if (src_set.uart0_tx) next_uart0_config[`VTIC_UC_TX_DONE] = 1'b1;
		if (src_set.uart0_rx) next_uart0_config[`VTIC_UC_RX_DONE] = 1'b1;
		if (src_set.uart1_tx) next_uart1_config[`VTIC_UC_TX_DONE] = 1'b1;
		if (src_set.uart1_rx) next_uart1_config[`VTIC_UC_RX_DONE] = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			uart0_config <= `VTIC_RST_UART_CONFIG;
			uart1_config <= `VTIC_RST_UART_CONFIG;
		end else begin
			uart0_config <= next_uart0_config;
			uart1_config <= next_uart1_config;
		end
	end

	// extended flags; msdma and wake-up cannot be set by a software write
	always_comb begin
		next_ext_flags = extended_interrupt_flags;
		if (sfr.wr && sfr.addr == `VTIC_ADDR_EXT_FLAGS) begin
			next_ext_flags = sfr.wdata[`VTIC_EF_WIDTH-1:0];
			next_ext_flags[`VTIC_EF_MSDMA] = extended_interrupt_flags[`VTIC_EF_MSDMA]
				& sfr.wdata[`VTIC_EF_MSDMA];
			next_ext_flags[`VTIC_EF_WAKE] = extended_interrupt_flags[`VTIC_EF_WAKE]
				& sfr.wdata[`VTIC_EF_WAKE];
		end
		if (hw_clear[`VTIC_SRC_DMA]) next_ext_flags[`VTIC_EF_DMA] = 1'b0;
		if (hw_clear[`VTIC_SRC_PCA]) next_ext_flags[`VTIC_EF_PCA] = 1'b0;
		if (hw_clear[`VTIC_SRC_PERIPH]) next_ext_flags[`VTIC_EF_PERIPH] = 1'b0;
		// sets last: an event on the clearing cycle is kept
		if (src_set.dma) next_ext_flags[`VTIC_EF_DMA] = 1'b1;
		if (src_set.counter_array) next_ext_flags[`VTIC_EF_PCA] = 1'b1;
		if (src_set.periph) next_ext_flags[`VTIC_EF_PERIPH] = 1'b1;
		if (src_set.softdma_mstimer) next_ext_flags[`VTIC_EF_MSDMA] = 1'b1;
		if (src_set.wakeup) next_ext_flags[`VTIC_EF_WAKE] = 1'b1;
		if (src_set.watchdog) next_ext_flags[`VTIC_EF_WDOG] = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) extended_interrupt_flags <= `VTIC_RST_EXT_FLAGS;
		else extended_interrupt_flags <= next_ext_flags;
	end

	// source vectors in natural priority order, index 0 first
	assign flag_vec = {
		extended_interrupt_flags,
		uart1_config[`VTIC_UC_TX_DONE] | uart1_config[`VTIC_UC_RX_DONE],
		src_set.timer_two_flag,
		uart0_config[`VTIC_UC_TX_DONE] | uart0_config[`VTIC_UC_RX_DONE],
		timer01_control[`VTIC_TC_T1_FLAG],
		timer01_control[`VTIC_TC_EXT_B_FLAG],
		timer01_control[`VTIC_TC_T0_FLAG],
		timer01_control[`VTIC_TC_EXT_A_FLAG]
	};
	assign en_vec  = {extended_interrupt_enable[`VTIC_EF_WIDTH-1:0], interrupt_enable[6:0]};
	assign grp_vec = {extended_interrupt_priority[`VTIC_EF_WIDTH-1:0], interrupt_priority[6:0]};
	assign pend    = flag_vec & en_vec & {N{interrupt_enable[`VTIC_EN_GLOBAL]}};

	// lowest index pending in each group; scanning downward lets low indices win
	always_comb begin
		hi_valid = 1'b0;
		lo_valid = 1'b0;
		hi_idx   = 4'h0;
		lo_idx   = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pend[i] && grp_vec[i]) begin
				hi_valid = 1'b1;
				hi_idx   = 4'(i);
			end
			if (pend[i] && !grp_vec[i]) begin
				lo_valid = 1'b1;
				lo_idx   = 4'(i);
			end
		end
	end

	// high may preempt low service; nothing preempts high service
	always_comb begin
		grant     = 1'b0;
		grant_idx = 4'h0;
		grant_grp = vtic_pkg::VTIC_GRP_LOW;
		if (hi_valid && !ins_hi) begin
			grant     = 1'b1;
			grant_idx = hi_idx;
			grant_grp = vtic_pkg::VTIC_GRP_HIGH;
		end else if (lo_valid && !ins_hi && !ins_lo) begin
			grant     = 1'b1;
			grant_idx = lo_idx;
		end
	end

	// offered request; dropped for one cycle on acknowledge to re-arbitrate
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_req    <= 1'b0;
			irq_vector <= `VTIC_VEC_BASE;
			served_idx <= 4'h0;
			served_grp <= vtic_pkg::VTIC_GRP_LOW;
		end else begin
			irq_req    <= grant & ~irq_ack;
			served_idx <= grant_idx;
			served_grp <= grant_grp;
			irq_vector <= 8'(`VTIC_VEC_BASE + `VTIC_VEC_STEP * {4'h0, grant_idx});
		end
	end

	// in-service levels: set on acknowledge, innermost cleared on return
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ins_hi <= 1'b0;
			ins_lo <= 1'b0;
		end else if (irq_ack) begin
			if (served_grp == vtic_pkg::VTIC_GRP_HIGH) ins_hi <= 1'b1;
			else ins_lo <= 1'b1;
		end else if (irq_return) begin
			if (ins_hi) ins_hi <= 1'b0;
			else ins_lo <= 1'b0;
		end
	end

	// registered read mux, one cycle behind the address
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sfr_rdata <= 8'h00;
		end else begin
			case (sfr.addr)
				`VTIC_ADDR_IRQ_ENABLE:      sfr_rdata <= interrupt_enable;
				`VTIC_ADDR_IRQ_PRIORITY:    sfr_rdata <= interrupt_priority;
				`VTIC_ADDR_EXT_ENABLE:      sfr_rdata <= extended_interrupt_enable;
				`VTIC_ADDR_EXT_PRIORITY:    sfr_rdata <= extended_interrupt_priority;
				`VTIC_ADDR_TIMER01_CONTROL: sfr_rdata <= timer01_control;
				`VTIC_ADDR_UART0_CONFIG:    sfr_rdata <= uart0_config;
				`VTIC_ADDR_UART1_CONFIG:    sfr_rdata <= uart1_config;
				`VTIC_ADDR_EXT_FLAGS:       sfr_rdata <= {2'h0, extended_interrupt_flags};
				`VTIC_ADDR_PERIPH_SUM_ONE:  sfr_rdata <= periph_sum_one_in;
				`VTIC_ADDR_PERIPH_SUM_TWO:  sfr_rdata <= periph_sum_two_in;
				default:                    sfr_rdata <= 8'h00;
			endcase
		end
	end

	// status outputs straight from flops
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			timer_run  <= 2'h0;
			in_service <= 2'h0;
		end else begin
			timer_run  <= {next_timer01_control[`VTIC_TC_T1_RUN],
				next_timer01_control[`VTIC_TC_T0_RUN]};
			in_service <= {ins_hi, ins_lo};
		end
	end

endmodule // vtic_core

`default_nettype wire

// ### tb/vtic_core_properties.sv
`timescale 1ns/1ps
`default_nettype none

// watches the core ports; one clock domain, so defaults are shared
module vtic_core_properties (
	input wire logic                clk_sys,
	input wire logic                sys_rst,
	input wire vtic_pkg::vtic_sfr_t sfr,
	input wire logic [7:0]          sfr_rdata,
	input wire logic [7:0]          periph_sum_one_in,
	input wire logic                irq_ack,
	input wire logic                irq_req,
	input wire logic [7:0]          irq_vector,
	input wire logic [1:0]          in_service
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	reset_outputs_a: assert property (disable iff (1'b0) sys_rst |=>
		!irq_req && irq_vector == 8'h03 && in_service == 2'b00 && sfr_rdata == 8'h00)
		else $error("outputs not at reset values");
	enable_readback_a: assert property (sfr.wr && sfr.addr == 8'ha8 ##1
		!sfr.wr && sfr.addr == 8'ha8 |=> sfr_rdata == $past(sfr.wdata, 2))
		else $error("interrupt enable readback wrong");
	unmapped_zero_a: assert property (!sfr.wr && sfr.addr == 8'h90 |=> sfr_rdata == 8'h00)
		else $error("unmapped address read nonzero");
	summary_read_a: assert property (sfr.addr == 8'h9e |=>
		sfr_rdata == $past(periph_sum_one_in))
		else $error("summary one readback wrong");
	prio_reserved_a: assert property (sfr.addr == 8'hb8 |=> !sfr_rdata[7])
		else $error("priority bit 7 reads one");
	vector_form_a: assert property (irq_req |->
		irq_vector[2:0] == 3'h3 && irq_vector <= 8'h63)
		else $error("vector outside table");
	ack_drop_a: assert property (irq_ack |=> !irq_req)
		else $error("request stayed up after ack");
	ack_service_a: assert property (irq_ack |-> ##2 in_service != 2'b00)
		else $error("ack did not enter service");
	high_blocks_a: assert property (in_service[1] && $past(in_service[1]) |-> !irq_req)
		else $error("request offered during high service");

	cover property (irq_ack && irq_vector == 8'h63);
	cover property (in_service == 2'b10);
	cover property (irq_ack && irq_vector == 8'h13);
endmodule // vtic_core_properties

bind vtic_core vtic_core_properties chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
	.periph_sum_one_in(periph_sum_one_in), .irq_ack(irq_ack), .irq_req(irq_req),
	.irq_vector(irq_vector), .in_service(in_service)
);

`default_nettype wire

// ### tb/vtic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// processor side: takes one request at a time, serves it, then returns
module vtic_cpu_model #(
	parameter int ACK_WAIT = 2,
	parameter int SVC_LEN  = 20
) (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       accept,
	input  wire logic       irq_req,
	input  wire logic [7:0] irq_vector,
	output logic            irq_ack,
	output logic            irq_return,
	output logic      [7:0] last_vec,
	output int              taken
);
	// drives just after the edge so the core sees stable pulses
	initial begin
		int cnt;
		int wt;
		bit busy;
		irq_ack = 1'b0;
		irq_return = 1'b0;
		last_vec = 8'h00;
		taken = 0;
		busy = 0;
		wt = 0;
		cnt = 0;
		forever begin
			@(posedge clk_sys);
			#1;
			irq_ack = 1'b0;
			irq_return = 1'b0;
			if (sys_rst) begin
				busy = 0;
				wt = 0;
			end else if (busy) begin
				// one return per ack, never in the ack cycle
				if (cnt == 0) begin
					irq_return = 1'b1;
					busy = 0;
				end else cnt--;
			end else if (accept && irq_req === 1'b1) begin
				// slow answer: the request must still stand when acked
				if (wt < ACK_WAIT) wt++;
				else begin
					irq_ack = 1'b1;
					last_vec = irq_vector;
					taken++;
					busy = 1;
					cnt = SVC_LEN;
					wt = 0;
				end
			end
		end
	end
endmodule // vtic_cpu_model

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic                clk_sys;
	logic                sys_rst;
	logic                pin_a_n;
	logic                pin_b_n;
	logic                t2;
	vtic_pkg::vtic_src_t pulses;
	vtic_pkg::vtic_src_t src_set;
	logic [7:0]          sum_one;
	logic [7:0]          sum_two;
	vtic_pkg::vtic_sfr_t sfr;
	logic [7:0]          sfr_rdata;
	logic                irq_ack;
	logic                irq_return;
	logic                irq_req;
	logic [7:0]          irq_vector;
	logic [1:0]          timer_run;
	logic [1:0]          in_service;
	logic                accept;
	logic [7:0]          last_vec;
	int                  taken;
	int                  mismatches;
	int                  n_compared;
	int                  cycles;
	logic [7:0]          addrs [9];

	// timer two is a level held by its timer, the rest are pulses
	always_comb begin
		src_set = pulses;
		src_set.timer_two_flag = t2;
	end

	vtic_core uut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ext_irq_pin_a_n(pin_a_n),
		.ext_irq_pin_b_n(pin_b_n), .src_set(src_set), .periph_sum_one_in(sum_one),
		.periph_sum_two_in(sum_two), .sfr(sfr), .sfr_rdata(sfr_rdata), .irq_ack(irq_ack),
		.irq_return(irq_return), .irq_req(irq_req), .irq_vector(irq_vector),
		.timer_run(timer_run), .in_service(in_service)
	);

	vtic_cpu_model #(.ACK_WAIT(2), .SVC_LEN(20)) cpu (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .accept(accept), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return),
		.last_vec(last_vec), .taken(taken)
	);

	// 10 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// hang guard, well above the several hundred cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		sfr.addr = a;
		sfr.wr = 1'b1;
		sfr.wdata = d;
		tick(1);
		sfr.wr = 1'b0;
	endtask

	// read data is registered, so it is looked at one edge later
	task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
		tick(1);
		sfr.addr = a;
		tick(1);
		check(sfr_rdata, exp);
	endtask

	task automatic pulse(input vtic_pkg::vtic_src_t m);
		tick(1);
		pulses = m;
		tick(1);
		pulses = '0;
	endtask

	// waits a bounded time for the core model to take a vector
	task automatic expect_vec(input logic [7:0] exp);
		int n0;
		n0 = taken;
		for (int i = 0; i < 80 && taken == n0; i++) tick(1);
		check((taken != n0) ? last_vec : 8'hff, exp);
	endtask

	initial begin
		vtic_pkg::vtic_src_t m;
		sys_rst = 1'b1;
		pin_a_n = 1'b1;
		pin_b_n = 1'b1;
		t2 = 1'b0;
		pulses = '0;
		sum_one = 8'h5a;
		sum_two = 8'ha5;
		sfr = '0;
		accept = 1'b1;
		mismatches = 0;
		n_compared = 0;
		cycles = 0;
		addrs = '{8'ha8, 8'hb8, 8'he8, 8'hf8, 8'h88, 8'h91, 8'h98, 8'hc0, 8'h90};
		tick(12);
		sys_rst = 1'b0;

		// reset values, unmapped hole, reserved and write-protected bits
		foreach (addrs[i]) sfr_rd(addrs[i], 8'h00);
		sfr_wr(8'hb8, 8'hff);
		sfr_rd(8'hb8, 8'h7f);
		sfr_wr(8'h91, 8'hff);
		sfr_rd(8'h91, 8'h27);
		sfr_wr(8'h91, 8'h00);
		sfr_wr(8'h90, 8'hff);
		sfr_rd(8'h90, 8'h00);
		sfr_rd(8'h9e, 8'h5a);
		sfr_rd(8'h9f, 8'ha5);
		sfr_wr(8'hb8, 8'h00);
		$display("test registers done");

		// source enabled but global bit off, then on; other source left off
		sfr_wr(8'ha8, 8'h02);
		m = '0;
		m.timer0_ovf = 1'b1;
		pulse(m);
		tick(8);
		check(8'(taken), 8'h00);
		sfr_wr(8'ha8, 8'h82);
		expect_vec(8'h0b);
		sfr_rd(8'h88, 8'h00);
		m = '0;
		m.timer1_ovf = 1'b1;
		pulse(m);
		tick(8);
		check(8'(taken), 8'h01);
		$display("test gating done");

		// every source pending at once, served strictly by natural priority
		accept = 1'b0;
		sfr_wr(8'h88, 8'h05);
		pin_a_n = 1'b0;
		pin_b_n = 1'b0;
		tick(4);
		pin_a_n = 1'b1;
		pin_b_n = 1'b1;
		m = '1;
		m.timer_two_flag = 1'b0;
		m.uart0_tx = 1'b0;
		m.uart1_rx = 1'b0;
		pulse(m);
		t2 = 1'b1;
		sfr_wr(8'ha8, 8'hff);
		sfr_wr(8'he8, 8'h3f);
		tick(30);
		accept = 1'b1;
		for (int i = 0; i < 13; i++) begin
			expect_vec(8'h03 + 8'(8 * i));
			case (i)
				4: sfr_wr(8'h98, 8'h00);
				5: t2 = 1'b0;
				6: sfr_wr(8'hc0, 8'h00);
				10: sfr_wr(8'h91, 8'h30);
				11: sfr_wr(8'h91, 8'h20);
				12: sfr_wr(8'h91, 8'h00);
				default: ;
			endcase
		end
		tick(40);
		check(8'(taken), 8'h0e);
		$display("test natural order done");

		// high group jumps ahead of a lower natural number
		accept = 1'b0;
		sfr_wr(8'hb8, 8'h40);
		sfr_wr(8'hf8, 8'h01);
		m = '0;
		m.timer0_ovf = 1'b1;
		m.uart1_tx = 1'b1;
		m.dma = 1'b1;
		pulse(m);
		accept = 1'b1;
		expect_vec(8'h33);
		sfr_wr(8'hc0, 8'h00);
		expect_vec(8'h3b);
		expect_vec(8'h0b);
		$display("test groups done");

		// pin b level mode: flag follows the pin, a written one is ignored
		tick(30);
		accept = 1'b0;
		sfr_wr(8'h88, 8'h00);
		pin_b_n = 1'b0;
		tick(6);
		sfr_rd(8'h88, 8'h08);
		pin_b_n = 1'b1;
		tick(6);
		sfr_wr(8'h88, 8'h08);
		sfr_rd(8'h88, 8'h00);
		pin_b_n = 1'b0;
		accept = 1'b1;
		expect_vec(8'h13);
		pin_b_n = 1'b1;
		// run bits come out on timer_run in the same edge, timer 0 in bit 0
		sfr_wr(8'h88, 8'h10);
		check({6'h00, timer_run}, 8'h01);
		$display("test level pin done");
		final_report();
	end
endmodule // testbench

`default_nettype wire
